/* logic/timer_control_flags.sv */
`timescale 1ns/1ps
`default_nettype none
`include "timer_flags_map.svh"

//Function
// - first register at 0x88, bits 0x88-0x8F
// - timer one overflow sets, vector clears
// - timer one counts only while run bit
// - timer zero overflow sets, vector clears
// - timer zero counts only while run bit
// - irq one flag, edge or level set
// - irq one type: one edge, zero level
// - irq zero flag, edge or level set
// - irq zero type: one edge, zero level
// - timer two overflow flag, blocked by baud
// - trigger edge capture/reload sets external flag
// - receive baud from timer two or one
// - transmit baud from timer two or one
// - trigger enable gates pin, not when baud
// - timer two advances only while run
// - source select: count pin or core clock
// - capture select: capture or autoreload
// - baud select forces autoreload on overflow
// - gate bit requires irq pin high
module timer_control_flags
    import timer_flags_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire tmr_evt_t tmr_evt,
    input wire vec_ack_t vec_ack,
    input wire logic timer_zero_gate,
    input wire logic timer_one_gate,
    input wire logic ext_irq_zero_pin,
    input wire logic ext_irq_one_pin,
    input wire logic timer_two_trigger_pin,
    input wire logic timer_two_count_pin,
    output logic timer_zero_enable,
    output logic timer_one_enable,
    output logic timer_two_enable,
    output logic timer_two_count_tick,
    output logic timer_two_capture,
    output logic timer_two_reload,
    output logic rx_baud_from_timer_two,
    output logic tx_baud_from_timer_two,
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    output logic [3:0] irq_request
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        logic [7:0] tric;
        logic [7:0] t2c;
        logic [7:0] rdata;
        logic capture;
        logic reload;
        logic rx_tick;
        logic tx_tick;
    } ctl_st_t;

    ctl_st_t st_ff;
    ctl_st_t nxt_st;

    // synchronised pins
    logic [3:0] pin_level; // trigger, count, irq one, irq zero
    logic [3:0] pin_fall;

    // decoded writes
    logic tric_hit;
    logic t2c_hit;
    logic [7:0] tric_mask;
    logic [7:0] tric_val;
    logic [7:0] t2c_mask;
    logic [7:0] t2c_val;

    // ----------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------
    // every pin is asynchronous to the core clock, so nothing reads
    // it before two flops; levels lag the pin by two edges and a
    // falling edge is reported on that same edge
    pin_sync #(
        .WIDTH(4)
    ) u_pins (
        .clock(clock),
        .rstn(rstn),
        .pin({timer_two_trigger_pin, timer_two_count_pin,
              ext_irq_one_pin, ext_irq_zero_pin}),
        .level(pin_level),
        .fall(pin_fall)
    );

    // ----------------------------------------------------------
    // address decode
    // ----------------------------------------------------------
    // one decoder per register; each turns byte or bit writes into
    // a mask and a value so both registers merge writes alike
    sfr_bit_decode #(
        .BASE(`TRIC_BYTE_ADDR)
    ) u_dec_tric (
        .req(sfr_req),
        .hit(tric_hit),
        .wmask(tric_mask),
        .wval(tric_val)
    );

    sfr_bit_decode #(
        .BASE(`T2C_BYTE_ADDR)
    ) u_dec_t2c (
        .req(sfr_req),
        .hit(t2c_hit),
        .wmask(t2c_mask),
        .wval(t2c_val)
    );

    // applies a masked software write to a byte
    function automatic logic [7:0] sw_merge(
        input logic [7:0] cur,
        input logic [7:0] mask,
        input logic [7:0] val
    );
        sw_merge = (cur & ~mask) | (val & mask);
    endfunction

    // one register's view for a read: whole byte, or one bit in bit 0
    function automatic logic [7:0] read_view(
        input logic [7:0] regval,
        input logic bit_op,
        input logic [2:0] bit_sel
    );
        read_view = bit_op ? {7'h00, regval[bit_sel]} : regval;
    endfunction

    // ----------------------------------------------------------
    // combinational helpers
    // ----------------------------------------------------------
    logic baud_any;
    logic trig_evt;
    logic t2_tick;
    logic [7:0] tric_sw;
    logic [7:0] t2c_sw;

    // baud select holds timer two in autoreload service
    assign baud_any = st_ff.t2c[`T2C_RX_BAUD] | st_ff.t2c[`T2C_TX_BAUD];
    // trigger falls honoured only when enabled and not clocking baud
    assign trig_evt = pin_fall[3] & st_ff.t2c[`T2C_TRIG_EN] & ~baud_any;
    // tick source: count pin edge or every core clock
    assign t2_tick = st_ff.t2c[`T2C_SRC] ? pin_fall[2] : 1'b1;
    // software view of both registers before hardware events apply
    assign tric_sw = sw_merge(st_ff.tric, tric_mask, tric_val);
    assign t2c_sw = sw_merge(st_ff.t2c, t2c_mask, t2c_val);

    // ----------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        // software writes first; hardware updates follow and win
        nxt_st.tric = tric_sw;
        nxt_st.t2c = t2c_sw;

        // timer one overflow flag
        if (vec_ack.t1) begin
            nxt_st.tric[`TRIC_T1_OVF] = 1'b0;
        end
        if (tmr_evt.t1_ovf) begin
            nxt_st.tric[`TRIC_T1_OVF] = 1'b1;
        end

        // timer zero overflow flag
        if (vec_ack.t0) begin
            nxt_st.tric[`TRIC_T0_OVF] = 1'b0;
        end
        if (tmr_evt.t0_ovf) begin
            nxt_st.tric[`TRIC_T0_OVF] = 1'b1;
        end

        // external irq one: edge latches, level follows pin
        // in level mode the pin owns the flag, so software writes to
        // it are overridden here; a vector ack there has no effect
        if (st_ff.tric[`TRIC_X1_TYPE]) begin
            if (vec_ack.x1) begin
                nxt_st.tric[`TRIC_X1_FLAG] = 1'b0;
            end
            if (pin_fall[1]) begin
                nxt_st.tric[`TRIC_X1_FLAG] = 1'b1;
            end
        end else begin
            nxt_st.tric[`TRIC_X1_FLAG] = ~pin_level[1];
        end

        // external irq zero: same scheme
        if (st_ff.tric[`TRIC_X0_TYPE]) begin
            if (vec_ack.x0) begin
                nxt_st.tric[`TRIC_X0_FLAG] = 1'b0;
            end
            if (pin_fall[0]) begin
                nxt_st.tric[`TRIC_X0_FLAG] = 1'b1;
            end
        end else begin
            nxt_st.tric[`TRIC_X0_FLAG] = ~pin_level[0];
        end

        // timer two overflow flag, never while baud selected
        if (tmr_evt.t2_ovf && !baud_any) begin
            nxt_st.t2c[`T2C_OVF] = 1'b1;
        end

        // capture or reload strobes to the timer two datapath
        // strobes are one-cycle pulses; capture and reload never
        // come together since the branches below are exclusive
        nxt_st.capture = 1'b0;
        nxt_st.reload = 1'b0;
        if (baud_any) begin
            // forced autoreload, capture select ignored
            nxt_st.reload = tmr_evt.t2_ovf;
        end else if (st_ff.t2c[`T2C_CAP]) begin
            nxt_st.capture = trig_evt;
        end else begin
            nxt_st.reload = tmr_evt.t2_ovf | trig_evt;
        end

        // external flag on any trigger-caused capture or reload
        if (trig_evt) begin
            nxt_st.t2c[`T2C_EXT] = 1'b1;
        end

        // baud ticks for serial modes 1 and 3
        nxt_st.rx_tick = st_ff.t2c[`T2C_RX_BAUD] ? tmr_evt.t2_ovf
                                                 : tmr_evt.t1_ovf;
        nxt_st.tx_tick = st_ff.t2c[`T2C_TX_BAUD] ? tmr_evt.t2_ovf
                                                 : tmr_evt.t1_ovf;

        // registered read data, previous state visible
        // a read in the same cycle as a write shows the old contents
        if (sfr_req.rd && tric_hit) begin
            nxt_st.rdata = read_view(st_ff.tric, sfr_req.bit_op, sfr_req.addr[2:0]);
        end else if (sfr_req.rd && t2c_hit) begin
            nxt_st.rdata = read_view(st_ff.t2c, sfr_req.bit_op, sfr_req.addr[2:0]);
        end else begin
            // unmapped or idle: read data rests at zero
            nxt_st.rdata = 8'h00;
        end
    end

    // ----------------------------------------------------------
    // state register
    // ----------------------------------------------------------
    // synchronous reset loads constants only; both registers come
    // up zero, so both irq inputs start in level mode
    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_ff.tric <= `TRIC_RESET;
            st_ff.t2c <= `T2C_RESET;
            st_ff.rdata <= 8'h00;
            st_ff.capture <= 1'b0;
            st_ff.reload <= 1'b0;
            st_ff.rx_tick <= 1'b0;
            st_ff.tx_tick <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------
    // outputs
    // ----------------------------------------------------------
    // read data straight from its flop
    assign sfr_rdata = st_ff.rdata;
    // hit is combinational from the request of this cycle
    assign sfr_hit = tric_hit | t2c_hit;

    // run bit alone, or with gate the irq pin must be high
    assign timer_zero_enable = st_ff.tric[`TRIC_T0_RUN]
                             & (~timer_zero_gate | pin_level[0]);
    assign timer_one_enable = st_ff.tric[`TRIC_T1_RUN]
                            & (~timer_one_gate | pin_level[1]);
    assign timer_two_enable = st_ff.t2c[`T2C_RUN];
    assign timer_two_count_tick = st_ff.t2c[`T2C_RUN] & t2_tick;
    // registered strobes to the timer two datapath
    assign timer_two_capture = st_ff.capture;
    assign timer_two_reload = st_ff.reload;
    assign rx_baud_from_timer_two = st_ff.t2c[`T2C_RX_BAUD];
    assign tx_baud_from_timer_two = st_ff.t2c[`T2C_TX_BAUD];
    // baud ticks lag the selected overflow by one edge
    assign rx_baud_tick = st_ff.rx_tick;
    assign tx_baud_tick = st_ff.tx_tick;
    // request lines: timer zero, irq zero, timer one, irq one
    assign irq_request = {st_ff.tric[`TRIC_X1_FLAG], st_ff.tric[`TRIC_T1_OVF],
                          st_ff.tric[`TRIC_X0_FLAG], st_ff.tric[`TRIC_T0_OVF]};

endmodule

`default_nettype wire

/* inc/timer_flags_map.svh */
`ifndef TIMER_FLAGS_MAP_SVH
`define TIMER_FLAGS_MAP_SVH

// -------------------------------------------------------------
// special function addresses
// -------------------------------------------------------------
`define TRIC_BYTE_ADDR 8'h88
`define TRIC_BIT_FIRST 8'h88
`define TRIC_BIT_LAST 8'h8F
`define T2C_BYTE_ADDR 8'hC8
`define T2C_BIT_FIRST 8'hC8
`define T2C_BIT_LAST 8'hCF

// -------------------------------------------------------------
// field positions, run/irq control register
// -------------------------------------------------------------
`define TRIC_T1_OVF 7
`define TRIC_T1_RUN 6
`define TRIC_T0_OVF 5
`define TRIC_T0_RUN 4
`define TRIC_X1_FLAG 3
`define TRIC_X1_TYPE 2
`define TRIC_X0_FLAG 1
`define TRIC_X0_TYPE 0

// -------------------------------------------------------------
// field positions, timer two control register
// -------------------------------------------------------------
`define T2C_OVF 7
`define T2C_EXT 6
`define T2C_RX_BAUD 5
`define T2C_TX_BAUD 4
`define T2C_TRIG_EN 3
`define T2C_RUN 2
`define T2C_SRC 1
`define T2C_CAP 0

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define TRIC_RESET 8'h00
`define T2C_RESET 8'h00

`endif

/* inc/timer_flags_pkg.sv */
package timer_flags_pkg;

    // sfr access from the core, byte or bit addressed
    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_op;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sfr_req_t;

    // timer events produced by the counting datapaths
    typedef struct packed {
        logic t0_ovf;
        logic t1_ovf;
        logic t2_ovf;
    } tmr_evt_t;

    // vector acknowledges from interrupt logic
    typedef struct packed {
        logic t0;
        logic t1;
        logic x0;
        logic x1;
    } vec_ack_t;

    // timer two edge detector states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HIGH,
        ST_LOW
    } edge_st_t;

endpackage

/* logic/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser with a falling-edge pulse behind it
module pin_sync
    import timer_flags_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] fall
);

    // ----------------------------------------------------------
    // state
    // ----------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } sync_st_t;

    sync_st_t st_ff;
    sync_st_t nxt_st;

    initial begin
        if (WIDTH < 1) $error("pin_sync width must be at least one");
    end

    // next state: first stage read only by second stage
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
    end

    // registers idle high, matching pulled-up pins
    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.s2;
    assign fall = st_ff.s3 & ~st_ff.s2;

endmodule

`default_nettype wire

/* logic/sfr_bit_decode.sv */
`timescale 1ns/1ps
`default_nettype none

// turns a byte or bit access into per-bit write strobes
module sfr_bit_decode
    import timer_flags_pkg::*;
#(
    parameter logic [7:0] BASE = 8'h88
) (
    input wire sfr_req_t req,
    output logic hit,
    output logic [7:0] wmask,
    output logic [7:0] wval
);

    initial begin
        if (BASE[2:0] != 3'h0) $error("base must be eight aligned");
    end

    // byte access hits the base only; bit access any of eight
    always_comb begin
        wmask = 8'h00;
        wval = req.wdata;
        if (req.bit_op) begin
            hit = (req.addr[7:3] == BASE[7:3]);
            if (req.wr && hit) begin
                wmask[req.addr[2:0]] = 1'b1;
                wval = {8{req.wdata[0]}};
            end
        end else begin
            hit = (req.addr == BASE);
            if (req.wr && hit) begin
                wmask = 8'hFF;
            end
        end
    end

endmodule

`default_nettype wire

/* verif/timer_control_flags_sva.sv */
`timescale 1ns/1ps
`default_nettype none

// watches the control block's ports
module timer_control_flags_sva
    import timer_flags_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire tmr_evt_t tmr_evt,
    input wire vec_ack_t vec_ack,
    input wire logic timer_one_gate,
    input wire logic ext_irq_one_pin,
    input wire logic timer_one_enable,
    input wire logic timer_two_enable,
    input wire logic timer_two_count_tick,
    input wire logic timer_two_capture,
    input wire logic timer_two_reload,
    input wire logic rx_baud_from_timer_two,
    input wire logic tx_baud_from_timer_two,
    input wire logic rx_baud_tick,
    input wire logic tx_baud_tick,
    input wire logic [3:0] irq_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    byte_decode_a: assert property (
        !sfr_req.bit_op |-> sfr_hit == (sfr_req.addr == 8'h88 || sfr_req.addr == 8'hC8))
        else $error("byte address decode wrong");
    unmapped_read_a: assert property (
        sfr_req.rd && !sfr_hit |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    t1_flag_set_a: assert property (
        tmr_evt.t1_ovf |=> irq_request[2]) else $error("timer one flag not set");
    t1_vec_clear_a: assert property (
        vec_ack.t1 && !tmr_evt.t1_ovf |=> !irq_request[2]) else $error("timer one flag kept");
    t0_flag_set_a: assert property (
        tmr_evt.t0_ovf |=> irq_request[0]) else $error("timer zero flag not set");
    t2_stopped_a: assert property (
        !timer_two_enable |-> !timer_two_count_tick) else $error("tick while stopped");
    gate_pin_a: assert property (
        timer_one_gate && timer_one_enable |-> $past(ext_irq_one_pin, 2))
        else $error("gated timer runs with pin low");
    rx_baud_a: assert property (
        (rx_baud_from_timer_two ? tmr_evt.t2_ovf : tmr_evt.t1_ovf) |=> rx_baud_tick)
        else $error("receive baud tick missing");
    tx_baud_a: assert property (
        (tx_baud_from_timer_two ? tmr_evt.t2_ovf : tmr_evt.t1_ovf) |=> tx_baud_tick)
        else $error("transmit baud tick missing");
    baud_reload_a: assert property (
        tmr_evt.t2_ovf && (rx_baud_from_timer_two || tx_baud_from_timer_two)
        |=> timer_two_reload && !timer_two_capture) else $error("baud overflow no reload");
    one_action_a: assert property (
        !(timer_two_capture && timer_two_reload)) else $error("capture and reload together");
endmodule

bind timer_control_flags timer_control_flags_sva i_timer_control_flags_sva (.clock, .rstn,
    .sfr_req, .sfr_rdata, .sfr_hit, .tmr_evt, .vec_ack, .timer_one_gate, .ext_irq_one_pin,
    .timer_one_enable, .timer_two_enable, .timer_two_count_tick, .timer_two_capture,
    .timer_two_reload, .rx_baud_from_timer_two, .tx_baud_from_timer_two, .rx_baud_tick,
    .tx_baud_tick, .irq_request);

`default_nettype wire

/* verif/irq_vectorer.sv */
`timescale 1ns/1ps
`default_nettype none

// interrupt vectoring logic: acks the lowest pending request after LAT+1 cycles
module irq_vectorer
    import timer_flags_pkg::*;
#(
    parameter int LAT = 3
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic en,
    input wire logic [3:0] irq_request,
    output vec_ack_t vec_ack
);
    logic [3:0] cnt_ff; // cycles a request has waited
    logic [3:0] pick; // lowest pending request, one-hot
    assign pick = irq_request & (~irq_request + 4'h1);
    // one ack pulse at a time, then wait again
    always_ff @(posedge clock) begin
        if (!rstn || !en || irq_request == 4'h0) begin
            cnt_ff <= 4'h0;
            vec_ack <= '0;
        end else if (cnt_ff == 4'(LAT)) begin
            cnt_ff <= 4'h0;
            vec_ack <= '{t0: pick[0], t1: pick[2], x0: pick[1], x1: pick[3]};
        end else begin
            cnt_ff <= cnt_ff + 4'h1;
            vec_ack <= '0;
        end
    end
endmodule

`default_nettype wire

/* verif/timer_control_flags_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_control_flags_bench
    import timer_flags_pkg::*;
;
    logic clock = 0, rstn = 0, g0 = 0, g1 = 0, trig = 1, cpin = 1, ven = 0;
    logic [1:0] xpin = 2'b11; // {irq one pin, irq zero pin}
    sfr_req_t req = '0;
    tmr_evt_t evt = '0;
    vec_ack_t ack;
    logic [7:0] rdata, d;
    logic hit, e0, e1, e2, tick, cap, rel, rxs, txs, rxt, txt;
    logic [3:0] irq;
    logic [2:0] s;
    int fails = 0, num_checks = 0;

    always #5 clock = ~clock;

    timer_control_flags i_timer_control_flags (.clock(clock), .rstn(rstn), .sfr_req(req),
        .sfr_rdata(rdata), .sfr_hit(hit), .tmr_evt(evt), .vec_ack(ack), .timer_zero_gate(g0),
        .timer_one_gate(g1), .ext_irq_zero_pin(xpin[0]), .ext_irq_one_pin(xpin[1]),
        .timer_two_trigger_pin(trig), .timer_two_count_pin(cpin), .timer_zero_enable(e0),
        .timer_one_enable(e1), .timer_two_enable(e2), .timer_two_count_tick(tick),
        .timer_two_capture(cap), .timer_two_reload(rel), .rx_baud_from_timer_two(rxs),
        .tx_baud_from_timer_two(txs), .rx_baud_tick(rxt), .tx_baud_tick(txt), .irq_request(irq));
    irq_vectorer i_irq_vectorer (.clock(clock), .rstn(rstn), .en(ven), .irq_request(irq),
        .vec_ack(ack));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task chk(input logic [7:0] seen, exp, input string m);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t %s: got %h want %h", $time, m, seen, exp);
        end
    endtask
    // one register access; read data is taken the cycle after
    task sfr(input logic w, r, b, input logic [7:0] a, wd);
        req = '{wr: w, rd: r, bit_op: b, addr: a, wdata: wd};
        step(1);
        d = rdata;
        req = '0;
        step(1);
    endtask
    // collects capture, reload and tick over six cycles
    task watch;
        s = '0;
        repeat (6) begin
            step(1);
            s |= {cap, rel, tick};
        end
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        sfr(0, 1, 0, 8'h88, 0); chk(d, 8'h00, "run reg reset");
        sfr(0, 1, 0, 8'hC8, 0); chk(d, 8'h00, "t2 reg reset");
        sfr(1, 0, 0, 8'h90, 8'hFF);
        sfr(0, 1, 0, 8'h90, 0); chk(d, 8'h00, "unmapped read");
        sfr(1, 0, 0, 8'h88, 8'h44);
        sfr(0, 1, 1, 8'h8E, 0); chk(d, 8'h01, "bit 8E read");
        sfr(0, 1, 1, 8'h8A, 0); chk(d, 8'h01, "bit 8A read");
        sfr(0, 1, 1, 8'h8F, 0); chk(d, 8'h00, "bit 8F read");
        sfr(1, 0, 0, 8'h88, 8'h00);
        req = '{wr: 0, rd: 0, bit_op: 1, addr: 8'hCF, wdata: 8'h00};
        #1; chk(hit, 1, "bit CF hit");
        req.addr = 8'hD0;
        #1; chk(hit, 0, "bit D0 miss");
        req = '0;
        $display("registers done");
    endtask
    task t_runs;
        sfr(1, 0, 1, 8'h8C, 1); chk({e2, e1, e0}, 3'b001, "run zero");
        sfr(1, 0, 1, 8'h8E, 1); chk({e2, e1, e0}, 3'b011, "run one");
        sfr(1, 0, 1, 8'hCA, 1); chk({e2, e1, e0}, 3'b111, "run two");
        g1 = 1; g0 = 1; xpin = 2'b00; step(3); chk(e1, 0, "gate pin low");
        chk(e0, 0, "gate zero low");
        xpin = 2'b11; step(3); chk(e1, 1, "gate pin high");
        chk(e0, 1, "gate zero high");
        g1 = 0; g0 = 0;
        sfr(1, 0, 0, 8'h88, 8'h00);
        sfr(1, 0, 0, 8'hC8, 8'h00); chk({e2, e1, e0}, 3'b000, "all stopped");
        $display("run bits done");
    endtask
    task t_ovf;
        evt.t1_ovf = 1; step(1); evt = '0; chk(irq, 4'b0100, "t1 flag");
        evt.t0_ovf = 1; step(1); evt = '0; chk(irq, 4'b0101, "t0 flag");
        ven = 1; step(12); chk(irq, 4'b0000, "vector clears");
        ven = 0;
        // hardware set meets a software clear in one cycle
        evt.t0_ovf = 1; req = '{wr: 1, rd: 0, bit_op: 1, addr: 8'h8D, wdata: 8'h00};
        step(1); evt = '0; req = '0; step(1);
        chk(irq, 4'b0001, "set beats write");
        sfr(1, 0, 1, 8'h8D, 0); chk(irq, 4'b0000, "software clear");
        $display("overflow flags done");
    endtask
    task t_ext;
        for (int i = 0; i < 2; i++) begin
            xpin[i] = 0; step(3); chk(irq[2*i+1], 1, "level set");
            xpin[i] = 1; step(3); chk(irq[2*i+1], 0, "level follows");
            sfr(1, 0, 1, 8'h88 + 8'(2*i), 1);
            xpin[i] = 0; step(2); xpin[i] = 1; step(4);
            chk(irq[2*i+1], 1, "edge held");
            ven = 1; step(8); ven = 0;
            chk(irq[2*i+1], 0, "edge vector clear");
        end
        $display("external irqs done");
    endtask
    task t_two;
        sfr(1, 0, 0, 8'hC8, 8'h0D); trig = 0; watch; trig = 1;
        chk(s, 3'b101, "capture");
        sfr(0, 1, 0, 8'hC8, 0); chk(d, 8'h4D, "ext flag");
        sfr(1, 0, 0, 8'hC8, 8'h0C); trig = 0; watch; trig = 1;
        chk(s, 3'b011, "trigger reload");
        sfr(1, 0, 0, 8'hC8, 8'h04); trig = 0; watch; trig = 1;
        chk(s, 3'b001, "trigger off");
        sfr(1, 0, 0, 8'hC8, 8'h3D); chk({rxs, txs}, 2'b11, "baud select");
        trig = 0; watch; trig = 1; chk(s, 3'b001, "baud ignores pin");
        evt.t2_ovf = 1; step(1); evt = '0; chk({cap, rel}, 2'b01, "baud reload");
        chk({rxt, txt}, 2'b11, "t2 baud ticks");
        evt.t1_ovf = 1; step(1); evt = '0; chk({rxt, txt}, 2'b00, "t1 not baud");
        sfr(0, 1, 0, 8'hC8, 0); chk(d, 8'h3D, "no flag in baud");
        sfr(1, 0, 0, 8'hC8, 8'h04);
        evt.t1_ovf = 1; evt.t2_ovf = 1; step(1); evt = '0;
        chk({cap, rel}, 2'b01, "overflow reload");
        chk({rxt, txt}, 2'b11, "t1 baud ticks");
        evt.t2_ovf = 1; step(1); evt = '0; chk({rxt, txt}, 2'b00, "t2 not baud");
        sfr(0, 1, 0, 8'hC8, 0); chk(d, 8'h84, "t2 flag");
        sfr(1, 0, 0, 8'hC8, 8'h06); chk(tick, 0, "pin idle");
        cpin = 0; watch; cpin = 1; chk(s, 3'b001, "pin counts");
        $display("timer two done");
    endtask

    initial begin
        repeat (10) @(posedge clock);
        #1;
        rstn = 1;
        t_regs;
        t_runs;
        t_ovf;
        t_ext;
        t_two;
        print_verdict;
    end
    // cuts a hang short
    initial begin
        repeat (3000) @(posedge clock);
        fails++;
        print_verdict;
    end
endmodule

`default_nettype wire
